// ==== verilog/kwdt_top.sv ====
`timescale 1ns/10ps

// Overview of operation
// - counter advances only on edges of the low-speed oscillator, never per system clock.
// - timeout select picks overflow at 2^8,10,12,14,15,16,17 or 18 oscillator periods.
// - watchdog counts whenever the enable key holds 01010 or 10101 and no key fault delay is pending.
// - any other key value causes a full device reset after the fault delay.
// - key fault reset sets flag bit 0; cleared only by software, zero at power-on.
// - control register powers up as 0x53: key 01010, timeout select 011.
// - overflow in normal running resets the device and sets the expiry flag.
// - overflow in sleep or idle sets expiry flag, resets only program counter and stack.
// - count clears on invalid key, watchdog clear instruction, or sleep entry.
// - exactly one dedicated clear instruction input clears the count.
// - flag register bits 7-3 read zero; bit 2 low voltage reset, bit 1 low voltage control fault.
module kwdt_top #(
  parameter int unsigned FAULT_DELAY_CYCLES = kwdt_pkg::FAULT_DELAY_CYC
) (
  input  wire logic                            clock,
  input  wire logic                            reset_n,
  input  wire logic                            low_speed_internal_osc,
  input  wire kwdt_pkg::kwdt_bus_req_t         bus_req,
  output logic [kwdt_pkg::DATA_W-1:0]          bus_rdata,
  input  wire logic                            watchdog_clear_instruction,
  input  wire logic                            sleep_entry_instruction,
  input  wire logic                            sleep_or_idle,
  input  wire logic                            low_voltage_reset_event,
  input  wire logic                            low_voltage_ctrl_fault_event,
  output logic                                 device_reset,
  output logic                                 pc_sp_reset,
  output logic                                 watchdog_expiry_flag,
  output logic                                 irq
);
  import kwdt_pkg::*;

  localparam logic [DLY_W-1:0] DELAY_LOAD = DLY_W'(FAULT_DELAY_CYCLES - 1);

  kwdt_ctrl_t        ctrl_reg;
  logic [2:0]        rstf_reg;
  logic              expiry_reg;
  logic [IRQ_W-1:0]  irq_status_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic [CNT_W-1:0]  count_reg;
  logic [DLY_W-1:0]  delay_reg;
  kwdt_state_t       state_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              irq_reg;
  logic              device_reset_reg;
  logic              pc_sp_reset_reg;

  logic              osc_meta_reg;
  logic              osc_sync_reg;
  logic              osc_prev_reg;

  logic              osc_tick;
  logic              key_valid;
  logic              fault_fire;
  logic              overflow;
  logic              count_clear;
  logic [DATA_W-1:0] rdata_next;
  logic [IRQ_W-1:0]  irq_events;
  logic              wr_ctrl;
  logic              wr_rstf;
  logic              wr_irq_st;
  logic              wr_irq_mask;

  // oscillator is asynchronous to clock; two flops before any use
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
    end else begin
      osc_meta_reg <= low_speed_internal_osc;
      osc_sync_reg <= osc_meta_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_sync_reg;
    end
  end

  // one enable pulse per oscillator rising edge; osc must stay below clock/4
  assign osc_tick = osc_sync_reg & ~osc_prev_reg;

  assign key_valid = (ctrl_reg.key == KEY_A) || (ctrl_reg.key == KEY_B);

  assign wr_ctrl     = bus_req.wr && (bus_req.addr == ADDR_CTRL);
  assign wr_rstf     = bus_req.wr && (bus_req.addr == ADDR_RSTF);
  assign wr_irq_st   = bus_req.wr && (bus_req.addr == ADDR_IRQ_ST);
  assign wr_irq_mask = bus_req.wr && (bus_req.addr == ADDR_IRQ_MASK);

  assign fault_fire = (state_reg == KW_FAULT_WAIT) && (delay_reg == '0);

  assign overflow = osc_tick && key_valid && (state_reg == KW_RUN)
                    && (count_reg == kwdt_terminal(ctrl_reg.tsel));

  // any clear, fault or overflow restarts the count at zero
  assign count_clear = watchdog_clear_instruction
                       || sleep_entry_instruction
                       || !key_valid
                       || fault_fire
                       || overflow;

  // control register; a firing key fault restores the power-on value so the
  // device comes back with a valid key instead of looping through resets
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_reg <= kwdt_ctrl_t'(CTRL_POR);
    end else if (fault_fire) begin
      ctrl_reg <= kwdt_ctrl_t'(CTRL_POR);
    end else if (wr_ctrl) begin
      ctrl_reg <= kwdt_ctrl_t'(bus_req.wdata);
    end
  end

  // fault sequencer: invalid key waits out the delay, then resets the device
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= KW_RUN;
      delay_reg <= '0;
    end else begin
      unique case (state_reg)
        KW_RUN: begin
          if (!key_valid) begin
            state_reg <= KW_FAULT_WAIT;
            delay_reg <= DELAY_LOAD;
          end
        end
        KW_FAULT_WAIT: begin
          if (delay_reg == '0) begin
            state_reg <= KW_RUN;
          end else begin
            delay_reg <= delay_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // watchdog counter, advanced only by oscillator ticks
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_reg <= CNT_ZERO;
    end else if (count_clear) begin
      count_reg <= CNT_ZERO;
    end else if (osc_tick && key_valid && (state_reg == KW_RUN)) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // reset outputs are one-cycle pulses
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      device_reset_reg <= 1'b0;
      pc_sp_reset_reg  <= 1'b0;
    end else begin
      device_reset_reg <= fault_fire || (overflow && !sleep_or_idle);
      pc_sp_reset_reg  <= overflow && sleep_or_idle;
    end
  end

  // expiry flag: set wins over a clear instruction in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      expiry_reg <= 1'b0;
    end else if (overflow) begin
      expiry_reg <= 1'b1;
    end else if (watchdog_clear_instruction) begin
      expiry_reg <= 1'b0;
    end
  end

  // reset cause flags: hardware sets, software writes a zero to clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rstf_reg <= '0;
    end else begin
      if (fault_fire) begin
        rstf_reg[RSTF_CTRL_FAULT_BIT] <= 1'b1;
      end else if (wr_rstf && !bus_req.wdata[RSTF_CTRL_FAULT_BIT]) begin
        rstf_reg[RSTF_CTRL_FAULT_BIT] <= 1'b0;
      end
      if (low_voltage_ctrl_fault_event) begin
        rstf_reg[RSTF_LV_CTRL_BIT] <= 1'b1;
      end else if (wr_rstf && !bus_req.wdata[RSTF_LV_CTRL_BIT]) begin
        rstf_reg[RSTF_LV_CTRL_BIT] <= 1'b0;
      end
      if (low_voltage_reset_event) begin
        rstf_reg[RSTF_LV_RESET_BIT] <= 1'b1;
      end else if (wr_rstf && !bus_req.wdata[RSTF_LV_RESET_BIT]) begin
        rstf_reg[RSTF_LV_RESET_BIT] <= 1'b0;
      end
    end
  end

  always_comb begin
    irq_events              = '0;
    irq_events[IRQ_OVF_BIT] = overflow;
    irq_events[IRQ_KEY_BIT] = fault_fire;
  end

  // sticky interrupt status, write one to clear; a new event beats the clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_status_reg <= '0;
    end else if (wr_irq_st) begin
      irq_status_reg <= (irq_status_reg & ~bus_req.wdata[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_mask_reg <= '0;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= bus_req.wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // read mux; unmapped bits and idle cycles read zero
  always_comb begin
    rdata_next = ZERO_BYTE;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CTRL: begin
          rdata_next = ctrl_reg;
        end
        ADDR_RSTF: begin
          rdata_next[RSTF_LV_RESET_BIT:0] = rstf_reg;
        end
        ADDR_STAT: begin
          rdata_next[STAT_EXPIRY_BIT]  = expiry_reg;
          rdata_next[STAT_ENABLED_BIT] = key_valid;
          rdata_next[STAT_PENDING_BIT] = (state_reg == KW_FAULT_WAIT);
        end
        ADDR_IRQ_ST: begin
          rdata_next[IRQ_W-1:0] = irq_status_reg;
        end
        ADDR_IRQ_MASK: begin
          rdata_next[IRQ_W-1:0] = irq_mask_reg;
        end
        ADDR_CNT_LO: begin
          rdata_next = count_reg[DATA_W-1:0];
        end
        ADDR_CNT_MID: begin
          rdata_next = count_reg[2*DATA_W-1:DATA_W];
        end
        ADDR_CNT_HI: begin
          rdata_next[CNT_W-2*DATA_W-1:0] = count_reg[CNT_W-1:2*DATA_W];
        end
      endcase
    end
  end

  // count bytes are read one at a time and may tear across an oscillator tick
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_reg <= ZERO_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata            = rdata_reg;
  assign irq                  = irq_reg;
  assign device_reset         = device_reset_reg;
  assign pc_sp_reset          = pc_sp_reset_reg;
  assign watchdog_expiry_flag = expiry_reg;

endmodule // kwdt_top

// ==== verilog/kwdt_pkg.sv ====
package kwdt_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned CNT_W  = 19;
  localparam int unsigned IRQ_W  = 2;

  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RSTF     = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_STAT     = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST   = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO   = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_CNT_MID  = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI   = 3'h7;

  localparam logic [DATA_W-1:0] CTRL_POR  = 8'h53;
  localparam logic [4:0]        KEY_A     = 5'h0a;
  localparam logic [4:0]        KEY_B     = 5'h15;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  localparam int unsigned RSTF_CTRL_FAULT_BIT = 0;
  localparam int unsigned RSTF_LV_CTRL_BIT    = 1;
  localparam int unsigned RSTF_LV_RESET_BIT   = 2;

  localparam int unsigned STAT_EXPIRY_BIT  = 0;
  localparam int unsigned STAT_ENABLED_BIT = 1;
  localparam int unsigned STAT_PENDING_BIT = 2;

  localparam int unsigned IRQ_OVF_BIT = 0;
  localparam int unsigned IRQ_KEY_BIT = 1;

  localparam logic [CNT_W-1:0] CNT_ZERO = 19'h0_0000;
  localparam logic [CNT_W-1:0] TERM_2P8  = 19'h0_00ff;
  localparam logic [CNT_W-1:0] TERM_2P10 = 19'h0_03ff;
  localparam logic [CNT_W-1:0] TERM_2P12 = 19'h0_0fff;
  localparam logic [CNT_W-1:0] TERM_2P14 = 19'h0_3fff;
  localparam logic [CNT_W-1:0] TERM_2P15 = 19'h0_7fff;
  localparam logic [CNT_W-1:0] TERM_2P16 = 19'h0_ffff;
  localparam logic [CNT_W-1:0] TERM_2P17 = 19'h1_ffff;
  localparam logic [CNT_W-1:0] TERM_2P18 = 19'h3_ffff;

  localparam int unsigned CLK_FREQ_HZ     = 10000000;
  localparam int unsigned FAULT_DELAY_US  = 100;
  localparam int unsigned FAULT_DELAY_CYC = (FAULT_DELAY_US * (CLK_FREQ_HZ / 1000000));
  localparam int unsigned DLY_W           = 16;

  typedef struct packed {
    logic [4:0] key;
    logic [2:0] tsel;
  } kwdt_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } kwdt_bus_req_t;

  typedef enum logic {
    KW_RUN,
    KW_FAULT_WAIT
  } kwdt_state_t;

  function automatic logic [CNT_W-1:0] kwdt_terminal(input logic [2:0] sel);
    logic [CNT_W-1:0] t;
    t = TERM_2P8;
    unique case (sel)
      3'h0: t = TERM_2P8;
      3'h1: t = TERM_2P10;
      3'h2: t = TERM_2P12;
      3'h3: t = TERM_2P14;
      3'h4: t = TERM_2P15;
      3'h5: t = TERM_2P16;
      3'h6: t = TERM_2P17;
      3'h7: t = TERM_2P18;
    endcase
    return t;
  endfunction

endpackage

// ==== tb/kwdt_assertions.sv ====
`timescale 1ns/10ps
module kwdt_checker #(
  parameter int unsigned FAULT_DELAY_CYCLES = 4
) (
  input wire logic                            clock,
  input wire logic                            reset_n,
  input wire kwdt_pkg::kwdt_bus_req_t         bus_req,
  input wire logic [kwdt_pkg::DATA_W-1:0]     bus_rdata,
  input wire logic                            watchdog_clear_instruction,
  input wire logic                            sleep_or_idle,
  input wire logic                            device_reset,
  input wire logic                            pc_sp_reset,
  input wire logic                            watchdog_expiry_flag,
  input wire logic                            irq
);
  import kwdt_pkg::*;
  // key fault reset lands a few cycles after the delay, allowing for pipeline slack
  localparam int DLY_LO = FAULT_DELAY_CYCLES;
  localparam int DLY_HI = FAULT_DELAY_CYCLES + 3;
  logic bad_key_wr;
  assign bad_key_wr = bus_req.wr && bus_req.addr == ADDR_CTRL &&
                      bus_req.wdata[7:3] != KEY_A && bus_req.wdata[7:3] != KEY_B;
  // a key fault legally resets the device up to DLY_HI cycles after a bad key write; mask that window
  int guard_cnt;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      guard_cnt <= 0;
    end else if (bad_key_wr) begin
      guard_cnt <= DLY_HI + 1;
    end else if (guard_cnt != 0) begin
      guard_cnt <= guard_cnt - 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  flag_high_zero_a: assert property (bus_req.rd && bus_req.addr == ADDR_RSTF |=> bus_rdata[7:3] == 5'h00)
    else $error("flag register high bits not zero");
  fault_wait_a: assert property (bad_key_wr |=> !device_reset [*2])
    else $error("key fault reset came without delay");
  fault_fire_a: assert property (bad_key_wr |-> ##[DLY_LO:DLY_HI] device_reset)
    else $error("key fault reset missing");
  reset_pulse_a: assert property (device_reset |=> !device_reset)
    else $error("device reset longer than one cycle");
  sleep_route_a: assert property (pc_sp_reset |-> !device_reset && watchdog_expiry_flag && $past(sleep_or_idle))
    else $error("sleep overflow routed wrongly");
  expiry_cause_a: assert property ($rose(watchdog_expiry_flag) |-> device_reset || pc_sp_reset)
    else $error("expiry flag set without overflow");
  expiry_hold_a: assert property (watchdog_expiry_flag && !watchdog_clear_instruction |=> watchdog_expiry_flag)
    else $error("expiry flag lost");
  clear_expiry_a: assert property (watchdog_clear_instruction |=> !watchdog_expiry_flag || device_reset || pc_sp_reset)
    else $error("clear left expiry flag set");
  // a clear in the overflow cycle may still see that cycle's reset one edge later
  clear_restart_a: assert property (watchdog_clear_instruction && guard_cnt == 0 |=> ##1 !(device_reset || pc_sp_reset) [*7])
    else $error("overflow right after clear");

  cover property (device_reset);
  cover property (pc_sp_reset);
  cover property (irq);
endmodule // kwdt_checker

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; $display("Error %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
  import kwdt_pkg::*;
  logic              clock = 1'b0;
  logic              reset_n = 1'b0;
  logic              osc = 1'b0;
  logic              osc_en = 1'b0;
  logic [2:0]        osc_div = 3'h0;
  kwdt_bus_req_t     bus_req = '0;
  logic [DATA_W-1:0] rdata;
  logic              clr = 1'b0;
  logic              slp = 1'b0;
  logic              sleep = 1'b0;
  logic              lvr = 1'b0;
  logic              lvc = 1'b0;
  logic              dev;
  logic              pcs;
  logic              expf;
  logic              irq;
  logic [1:0]        seen;
  int                n_ticks = 0;
  int                n_errors = 0;
  int                checks = 0;
  localparam logic [7:0] CT [3] = '{8'ha8, 8'h50, 8'h51};
  localparam int         TK [3] = '{256, 256, 1024};

  kwdt_top #(.FAULT_DELAY_CYCLES(4)) kwdt_top_inst (.clock(clock), .reset_n(reset_n),
    .low_speed_internal_osc(osc), .bus_req(bus_req), .bus_rdata(rdata), .watchdog_clear_instruction(clr),
    .sleep_entry_instruction(slp), .sleep_or_idle(sleep), .low_voltage_reset_event(lvr),
    .low_voltage_ctrl_fault_event(lvc), .device_reset(dev), .pc_sp_reset(pcs), .watchdog_expiry_flag(expf),
    .irq(irq));

  always #50 clock = ~clock;
  // slow tick, 8 system clocks a period, well under clock/4
  always @(posedge clock) begin
    osc_div <= osc_en ? osc_div + 3'h1 : 3'h0;
    osc <= osc_en && osc_div[2];
    if (!osc_en) begin
      n_ticks <= 0;
    end else if (osc_div == 3'h3) begin
      n_ticks <= n_ticks + 1;
    end
  end

  task automatic report_and_stop();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    n_errors++;
    $display("Error %0t: %0s", $time, m);
    report_and_stop();
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: ZERO_BYTE, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req <= '0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic pulse(input int s);
    @(posedge clock);
    clr <= (s == 0);
    slp <= (s == 1);
    lvr <= (s == 2);
    lvc <= (s == 3);
    @(posedge clock);
    {clr, slp, lvr, lvc} <= 4'h0;
    #1;
  endtask
  task automatic wait_rst(input int lim);
    seen = 2'b00;
    for (int i = 0; i < lim && seen == 2'b00; i++) begin
      @(posedge clock);
      #1;
      seen = {pcs, dev};
    end
    if (seen == 2'b00) fail("no reset pulse");
  endtask

  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rd(ADDR_CTRL, CTRL_POR);
    rd(ADDR_RSTF, ZERO_BYTE);
    wr(ADDR_STAT, 8'hff);
    rd(ADDR_STAT, 8'h02);
    $display("test reset done");
    // sleep overflow first so the expiry flag is seen rising from zero
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CTRL, CT[k]);
      sleep <= (k == 0);
      pulse(k == 0 ? 1 : 0);
      if (k > 0) `CHK(expf, 1'b0)
      osc_en <= 1'b1;
      for (int i = 0; i < 1000 && n_ticks < 100; i++) @(posedge clock);
      if (n_ticks != 100) fail("ticks stalled");
      repeat (2) @(posedge clock);
      #1;
      `CHK(expf, 1'b0)
      pulse(k == 0 ? 1 : 0);
      wait_rst(9500);
      `CHK(n_ticks, 100 + TK[k])
      `CHK(seen, (k == 0) ? 2'b10 : 2'b01)
      `CHK(expf, 1'b1)
      osc_en <= 1'b0;
      sleep <= 1'b0;
      rd(ADDR_STAT, 8'h03);
      rd(ADDR_CTRL, CT[k]);
      $display("test overflow %0d done", k);
    end
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 8'h02);
    wr(ADDR_CTRL, 8'h00);
    wait_rst(20);
    `CHK(seen, 2'b01)
    rd(ADDR_RSTF, 8'h01);
    rd(ADDR_CTRL, CTRL_POR);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_ST, 8'h03);
    rd(ADDR_IRQ_ST, ZERO_BYTE);
    `CHK(irq, 1'b0)
    wr(ADDR_RSTF, 8'hff);
    rd(ADDR_RSTF, 8'h01);
    wr(ADDR_RSTF, ZERO_BYTE);
    rd(ADDR_RSTF, ZERO_BYTE);
    $display("test key fault done");
    pulse(2);
    pulse(3);
    rd(ADDR_RSTF, 8'h06);
    wr(ADDR_RSTF, ZERO_BYTE);
    rd(ADDR_RSTF, ZERO_BYTE);
    $display("test flags done");
    // longest timeout, so 300 ticks after a clear must read back as a plain count
    wr(ADDR_CTRL, 8'h57);
    pulse(0);
    osc_en <= 1'b1;
    for (int i = 0; i < 3000 && n_ticks < 300; i++) @(posedge clock);
    if (n_ticks != 300) fail("ticks stalled");
    osc_en <= 1'b0;
    repeat (6) @(posedge clock);
    rd(ADDR_CNT_LO, 8'h2c);
    rd(ADDR_CNT_MID, 8'h01);
    rd(ADDR_CNT_HI, ZERO_BYTE);
    $display("test count done");
    report_and_stop();
  end
endmodule // testbench

bind kwdt_top kwdt_checker #(.FAULT_DELAY_CYCLES(FAULT_DELAY_CYCLES)) kwdt_checker_inst (.clock(clock),
  .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .watchdog_clear_instruction(watchdog_clear_instruction), .sleep_or_idle(sleep_or_idle),
  .device_reset(device_reset), .pc_sp_reset(pc_sp_reset), .watchdog_expiry_flag(watchdog_expiry_flag),
  .irq(irq));
